// file: src/acrs_pkg.sv
// constants and carrier types for the conversion result slot block
package acrs_pkg;

    localparam int NUM_SLOTS = 4;
    localparam int VALUE_W = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IRQ_W = 2 * NUM_SLOTS;

    // slot order: 0 = slot 5, 1 = slot 6, 2 = slot 7, 3 = priority slot
    localparam int SLOT5_IDX = 0;
    localparam int SLOT6_IDX = 1;
    localparam int SLOT7_IDX = 2;
    localparam int PRIO_IDX = 3;

    // field layout of every result word
    localparam int VALUE_LSB = 6;
    localparam int VALUE_MSB = 15;
    localparam int OVERRUN_BIT = 1;
    localparam int STORED_BIT = 0;

    // byte addresses on the register bus
    localparam logic [ADDR_W-1:0] ADDR_SLOT5 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SLOT6 = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SLOT7 = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PRIO = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h14;

    // interrupt status layout: stored events low, overrun events high
    localparam int IRQ_STORED_LSB = 0;
    localparam int IRQ_OVERRUN_LSB = NUM_SLOTS;

    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_ZERO = 8'h00;
    localparam logic [VALUE_W-1:0] VALUE_ZERO = 10'h000;
    localparam logic [NUM_SLOTS-1:0] SEL_NONE = 4'h0;

    // one result handed over by the converter core
    typedef struct packed {
        logic valid;
        logic [VALUE_W-1:0] value;
    } acrs_store_t;

    // stored state of one slot
    typedef struct packed {
        logic [VALUE_W-1:0] value;
        logic overrun;
        logic stored;
    } acrs_slot_t;

    // bus request as seen by the slave
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } acrs_req_t;

    localparam acrs_slot_t SLOT_RESET = '{
        value: 10'h000,
        overrun: 1'b0,
        stored: 1'b0
    };

endpackage

// file: src/acrs_reset_sync.sv
// two-stage release synchroniser for the active low reset
`timescale 1ns/1ps
module acrs_reset_sync (
    // clock and raw reset
    input wire logic mclk,
    input wire logic rstn,
    // synchronised reset, active low
    output logic rstnSync
);

    logic stage1_reg;
    logic stage2_reg;

    // assert at once, release two edges later
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    assign rstnSync = stage2_reg;

endmodule

// file: src/acrs_result_slot.sv
// one result holding slot with stored and overrun flags
`timescale 1ns/1ps
module acrs_result_slot (
    // clock and reset
    input wire logic mclk,
    input wire logic rstnSync,
    // converter side
    input acrs_pkg::acrs_store_t storeReq,
    // bus side: this slot was read this cycle
    input wire logic readClr,
    // state and events
    output acrs_pkg::acrs_slot_t slotQ,
    output logic storeEvt,
    output logic overrunEvt
);

    acrs_pkg::acrs_slot_t slot_reg;

    // a store in the same cycle as a read wins: the new value stays unread
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            slot_reg <= acrs_pkg::SLOT_RESET;
        end
        else if (storeReq.valid)
        begin
            slot_reg.value <= storeReq.value;
            slot_reg.stored <= 1'b1;
            slot_reg.overrun <= !readClr
                && (slot_reg.overrun || slot_reg.stored);
        end
        else if (readClr)
        begin
            slot_reg.stored <= 1'b0;
            slot_reg.overrun <= 1'b0;
        end
    end

    assign slotQ = slot_reg;
    assign storeEvt = storeReq.valid;
    // overwrite of an unread value, not counting one read right now
    assign overrunEvt = storeReq.valid && slot_reg.stored && !readClr;

endmodule

// file: src/acrs_result_regs.sv
// result slots 5, 6, 7 and priority with bus slave and interrupt
//
// Notes on behaviour
// R1 - value in bits 15:6, other bits zero
// R2 - separate slots 5, 6 and 7
// R3 - overwrite of unread value sets overrun bit 1
// R4 - reading a slot clears its overrun flag
// R5 - every store sets the stored flag bit 0
// R6 - reading the value clears the stored flag
// R7 - stored at bit 0, overrun at bit 1
// R8 - priority slot takes priority results only
// R9 - writes to slots ignored; reset clears all
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module acrs_result_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register bus
    input wire logic [acrs_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [acrs_pkg::DATA_W-1:0] avs_writedata,
    output logic [acrs_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // converter store strobes, one per slot
    input acrs_pkg::acrs_store_t [acrs_pkg::NUM_SLOTS-1:0] storeReq,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [acrs_pkg::NUM_SLOTS-1:0] slotSel(
        input logic [acrs_pkg::ADDR_W-1:0] addr
    );
        logic [acrs_pkg::NUM_SLOTS-1:0] sel;
        sel = acrs_pkg::SEL_NONE;
        unique case (addr)
            acrs_pkg::ADDR_SLOT5: sel[acrs_pkg::SLOT5_IDX] = 1'b1;
            acrs_pkg::ADDR_SLOT6: sel[acrs_pkg::SLOT6_IDX] = 1'b1;
            acrs_pkg::ADDR_SLOT7: sel[acrs_pkg::SLOT7_IDX] = 1'b1;
            acrs_pkg::ADDR_PRIO: sel[acrs_pkg::PRIO_IDX] = 1'b1;
            default: sel = acrs_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    function automatic logic [acrs_pkg::DATA_W-1:0] slotWord(
        input acrs_pkg::acrs_slot_t s
    );
        logic [acrs_pkg::DATA_W-1:0] w;
        w = acrs_pkg::WORD_ZERO;
        w[acrs_pkg::VALUE_MSB:acrs_pkg::VALUE_LSB] = s.value; // [R1]
        w[acrs_pkg::OVERRUN_BIT] = s.overrun; // [R7]
        w[acrs_pkg::STORED_BIT] = s.stored; // [R7]
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic rstnSync;

    acrs_reset_sync u_reset_sync (
        .mclk(mclk),
        .rstn(rstn),
        .rstnSync(rstnSync)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then the answer

    typedef enum logic [1:0] {
        ACRS_IDLE = 2'b01,
        ACRS_ACK = 2'b10
    } acrs_bus_state_t;

    acrs_bus_state_t busState_reg;
    acrs_bus_state_t busState_next;
    acrs_pkg::acrs_req_t req;

    assign req = '{
        read: avs_read,
        write: avs_write,
        address: avs_address,
        writedata: avs_writedata
    };

    always_comb
    begin
        busState_next = busState_reg;
        unique case (busState_reg)
            ACRS_IDLE:
            begin
                if (req.read || req.write)
                begin
                    busState_next = ACRS_ACK;
                end
            end
            ACRS_ACK:
            begin
                busState_next = ACRS_IDLE;
            end
            default: busState_next = ACRS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            busState_reg <= ACRS_IDLE;
        end
        else
        begin
            busState_reg <= busState_next;
        end
    end

    assign avs_waitrequest = (busState_reg != ACRS_ACK);

    // reads sample and clear at the edge that enters the answer cycle,
    // so data and clearing refer to the same slot contents
    logic readTake;
    logic writeTake;
    logic [acrs_pkg::NUM_SLOTS-1:0] readSel;

    assign readTake = (busState_reg == ACRS_IDLE) && req.read;
    assign writeTake = (busState_reg == ACRS_ACK) && req.write;
    assign readSel = readTake ? slotSel(req.address) : acrs_pkg::SEL_NONE;

    ////////////////////////////////////////////////////////////////////////
    // result slots

    acrs_pkg::acrs_slot_t [acrs_pkg::NUM_SLOTS-1:0] slotQ;
    logic [acrs_pkg::NUM_SLOTS-1:0] storeEvt;
    logic [acrs_pkg::NUM_SLOTS-1:0] overrunEvt;

    // each slot has its own store strobe, so slots never share data
    genvar gi;
    generate
        for (gi = 0; gi < acrs_pkg::NUM_SLOTS; gi++)
        begin : g_slot
            acrs_result_slot u_slot (
                .mclk(mclk),
                .rstnSync(rstnSync),
                .storeReq(storeReq[gi]), // [R2] [R8]
                .readClr(readSel[gi]), // [R4] [R6]
                .slotQ(slotQ[gi]),
                .storeEvt(storeEvt[gi]), // [R5]
                .overrunEvt(overrunEvt[gi]) // [R3]
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [acrs_pkg::IRQ_W-1:0] irqStatus_reg;
    logic [acrs_pkg::IRQ_W-1:0] irqMask_reg;
    logic [acrs_pkg::IRQ_W-1:0] irqEvents;
    logic [acrs_pkg::IRQ_W-1:0] irqClear;
    logic maskWrite;

    assign irqEvents = {overrunEvt, storeEvt};
    assign irqClear = (writeTake && req.address == acrs_pkg::ADDR_IRQ_STATUS)
        ? req.writedata[acrs_pkg::IRQ_W-1:0] : acrs_pkg::IRQ_ZERO;
    assign maskWrite = writeTake && req.address == acrs_pkg::ADDR_IRQ_MASK;

    // a new event beats a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            irqStatus_reg <= acrs_pkg::IRQ_ZERO;
        end
        else
        begin
            irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvents;
        end
    end

    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            irqMask_reg <= acrs_pkg::IRQ_ZERO;
        end
        else if (maskWrite)
        begin
            irqMask_reg <= req.writedata[acrs_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irqStatus_reg & irqMask_reg);

    ////////////////////////////////////////////////////////////////////////
    // read data; slot writes fall through and change nothing

    logic [acrs_pkg::DATA_W-1:0] readWord;

    always_comb
    begin
        readWord = acrs_pkg::WORD_ZERO;
        unique case (req.address)
            acrs_pkg::ADDR_SLOT5:
                readWord = slotWord(slotQ[acrs_pkg::SLOT5_IDX]);
            acrs_pkg::ADDR_SLOT6:
                readWord = slotWord(slotQ[acrs_pkg::SLOT6_IDX]);
            acrs_pkg::ADDR_SLOT7:
                readWord = slotWord(slotQ[acrs_pkg::SLOT7_IDX]);
            acrs_pkg::ADDR_PRIO:
                readWord = slotWord(slotQ[acrs_pkg::PRIO_IDX]);
            acrs_pkg::ADDR_IRQ_STATUS:
                readWord[acrs_pkg::IRQ_W-1:0] = irqStatus_reg;
            acrs_pkg::ADDR_IRQ_MASK:
                readWord[acrs_pkg::IRQ_W-1:0] = irqMask_reg;
            // unmapped addresses read as zero
            default: readWord = acrs_pkg::WORD_ZERO;
        endcase
    end

    always_ff @(posedge mclk or negedge rstnSync)
    begin
        if (!rstnSync)
        begin
            avs_readdata <= acrs_pkg::WORD_ZERO;
        end
        else if (readTake)
        begin
            avs_readdata <= readWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the bus side

    chk_reserved_zero: assert property ( // [R1]
        @(posedge mclk) disable iff (!rstnSync)
        (!avs_waitrequest && avs_read
            && slotSel(avs_address) != acrs_pkg::SEL_NONE)
        |-> (avs_readdata[31:16] == 16'h0000 && avs_readdata[5:2] == 4'h0))
        else $error("reserved bits of a result word not zero");

    chk_read_answer: assert property ( // [R7]
        @(posedge mclk) disable iff (!rstnSync)
        (busState_reg == ACRS_IDLE && avs_read)
        |=> (!avs_waitrequest && avs_readdata == $past(readWord)))
        else $error("read answer late or not the sampled word");

    chk_one_wait: assert property (
        @(posedge mclk) disable iff (!rstnSync)
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after exactly one wait cycle");

    chk_irq_sticky: assert property (
        @(posedge mclk) disable iff (!rstnSync)
        (|irqEvents) |=> ((irqStatus_reg & $past(irqEvents))
            == $past(irqEvents)))
        else $error("interrupt event not latched");

    chk_irq_mask: assert property (
        @(posedge mclk) disable iff (!rstnSync)
        (irqMask_reg == acrs_pkg::IRQ_ZERO) |-> !irq)
        else $error("interrupt raised with all sources masked");

    // an unmasked event raises the line next cycle, even against a clear
    chk_irq_raise: assert property (
        @(posedge mclk) disable iff (!rstnSync)
        ((|(irqEvents & irqMask_reg)) && !maskWrite) |=> irq)
        else $error("unmasked event did not raise the interrupt");

    chk_w1c_clear: assert property (
        @(posedge mclk) disable iff (!rstnSync)
        (|irqClear) |=> ((irqStatus_reg & $past(irqClear)
            & ~$past(irqEvents)) == acrs_pkg::IRQ_ZERO))
        else $error("write-one clear left a status bit set");

    chk_data_stands: assert property (
        @(posedge mclk) disable iff (!rstnSync)
        !readTake |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    chk_reset_quiet: assert property ( // [R9]
        @(posedge mclk)
        !rstnSync |-> (avs_waitrequest && !irq
            && avs_readdata == acrs_pkg::WORD_ZERO))
        else $error("outputs not quiet during reset");

    ////////////////////////////////////////////////////////////////////////
    // checks on every slot

    generate
        for (gi = 0; gi < acrs_pkg::NUM_SLOTS; gi++)
        begin : g_chk
            chk_slot_isolate: assert property ( // [R2] [R8]
                @(posedge mclk) disable iff (!rstnSync)
                !storeReq[gi].valid |=> $stable(slotQ[gi].value))
                else $error("slot value changed without its own store");

            chk_overrun_set: assert property ( // [R3]
                @(posedge mclk) disable iff (!rstnSync)
                (storeReq[gi].valid && slotQ[gi].stored && !readSel[gi])
                |=> slotQ[gi].overrun)
                else $error("overwrite of unread value left overrun clear");

            chk_overrun_clear: assert property ( // [R4]
                @(posedge mclk) disable iff (!rstnSync)
                (readSel[gi] && !storeReq[gi].valid)
                |=> !slotQ[gi].overrun ##1 (!slotQ[gi].overrun
                    || $past(storeReq[gi].valid)))
                else $error("overrun not cleared by a read");

            chk_stored_set: assert property ( // [R5]
                @(posedge mclk) disable iff (!rstnSync)
                storeReq[gi].valid |=> (slotQ[gi].stored
                    && slotQ[gi].value == $past(storeReq[gi].value)))
                else $error("store did not set flag or value");

            chk_stored_clear: assert property ( // [R6]
                @(posedge mclk) disable iff (!rstnSync)
                (readSel[gi] && !storeReq[gi].valid) |=> !slotQ[gi].stored)
                else $error("stored flag not cleared by a read");

            chk_slot_fields: assert property ( // [R1] [R7]
                @(posedge mclk) disable iff (!rstnSync)
                readSel[gi] |=> (avs_readdata[acrs_pkg::VALUE_MSB:
                    acrs_pkg::VALUE_LSB] == $past(slotQ[gi].value)
                    && avs_readdata[acrs_pkg::OVERRUN_BIT]
                        == $past(slotQ[gi].overrun)
                    && avs_readdata[acrs_pkg::STORED_BIT]
                        == $past(slotQ[gi].stored)))
                else $error("slot word fields in the wrong place");

            chk_write_ignored: assert property ( // [R9]
                @(posedge mclk) disable iff (!rstnSync)
                (writeTake && slotSel(req.address) != acrs_pkg::SEL_NONE
                    && !storeReq[gi].valid && !readSel[gi])
                |=> $stable(slotQ[gi]))
                else $error("bus write altered a result slot");

            chk_clean_reset: assert property ( // [R9]
                @(posedge mclk)
                $rose(rstnSync) |-> (slotQ[gi] == acrs_pkg::SLOT_RESET))
                else $error("slot not zero after reset");
        end
    endgenerate

endmodule

// file: testbench/acrs_result_regs_tb_top.sv
// self-checking bench for the conversion result slot block
`timescale 1ns/1ps
module acrs_result_regs_tb_top;

    ////////////////////////////////////////////////////////////////////////
    // signals
    logic mclk;
    logic rstn;
    logic [acrs_pkg::ADDR_W-1:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [acrs_pkg::DATA_W-1:0] avsWritedata;
    logic [acrs_pkg::DATA_W-1:0] avsReaddata;
    logic avsWaitrequest;
    acrs_pkg::acrs_store_t [acrs_pkg::NUM_SLOTS-1:0] storeReq;
    logic irq;
    int fail_count;
    int cmp_count;
    logic [acrs_pkg::ADDR_W-1:0] slotAddr [acrs_pkg::NUM_SLOTS];
    logic [acrs_pkg::VALUE_W-1:0] vals [acrs_pkg::NUM_SLOTS];

    acrs_result_regs dut_u (
        .mclk(mclk),
        .rstn(rstn),
        .avs_address(avsAddress),
        .avs_read(avsRead),
        .avs_write(avsWrite),
        .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest),
        .storeReq(storeReq),
        .irq(irq)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] mkWord(input logic [9:0] v,
        input logic ovr, input logic st);
        return {16'h0000, v, 4'h0, ovr, st};
    endfunction

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t irq=%h exp=%h", $time, got, exp);
        end
    endtask

    // values read right after a rising edge are those that edge sampled;
    // the request stands until waitrequest is seen low, only the
    // watchdog ends a wait that never finishes
    task automatic busXfer(input logic wr, input logic [7:0] addr,
        input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge mclk);
        avsAddress <= addr;
        avsRead <= ~wr;
        avsWrite <= wr;
        avsWritedata <= wdata;
        @(posedge mclk);
        while (avsWaitrequest !== 1'b0)
            @(posedge mclk);
        rdata = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic checkRead(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        busXfer(1'b0, addr, 32'h0000_0000, d);
        checkWord(d, exp);
    endtask

    task automatic checkSlot(input int i, input logic ovr, input logic st);
        checkRead(slotAddr[i], mkWord(vals[i], ovr, st));
    endtask

    task automatic busWrite(input logic [7:0] addr, input logic [31:0] d);
        logic [31:0] unused;
        busXfer(1'b1, addr, d, unused);
    endtask

    task automatic checkIrq(input logic exp);
        @(negedge mclk);
        checkBit(irq, exp);
    endtask

    // one-cycle store pulse; value lines toggle once the pulse is over
    task automatic storeVal(input int idx, input logic [9:0] v);
        @(posedge mclk);
        storeReq[idx] <= '{valid: 1'b1, value: v};
        @(posedge mclk);
        storeReq[idx] <= '{valid: 1'b0, value: ~v};
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the full sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // tests
    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        rstn = 1'b0;
        avsAddress = 8'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0000_0000;
        storeReq = '0;
        slotAddr = '{acrs_pkg::ADDR_SLOT5, acrs_pkg::ADDR_SLOT6,
            acrs_pkg::ADDR_SLOT7, acrs_pkg::ADDR_PRIO};
        vals = '{10'h3FF, 10'h001, 10'h2AA, 10'h155};
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < acrs_pkg::NUM_SLOTS; i++)
            checkRead(slotAddr[i], 32'h0000_0000);
        checkRead(acrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
        checkRead(acrs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        checkIrq(1'b0);
        // all slots loaded first, so a shared register would show up
        for (int i = 0; i < acrs_pkg::NUM_SLOTS; i++)
            storeVal(i, vals[i]);
        for (int i = 0; i < acrs_pkg::NUM_SLOTS; i++)
        begin
            checkSlot(i, 1'b0, 1'b1);
            checkSlot(i, 1'b0, 1'b0);
            busWrite(slotAddr[i], 32'hFFFF_FFFF);
            checkSlot(i, 1'b0, 1'b0);
            storeVal(i, ~vals[i]);
            storeVal(i, vals[i]);
            checkSlot(i, 1'b1, 1'b1);
            checkSlot(i, 1'b0, 1'b0);
        end
        // interrupt: every store and overrun event is now pending
        checkRead(acrs_pkg::ADDR_IRQ_STATUS, 32'h0000_00FF);
        checkIrq(1'b0);
        busWrite(acrs_pkg::ADDR_IRQ_MASK, 32'h0000_0010);
        checkIrq(1'b1);
        checkRead(acrs_pkg::ADDR_IRQ_MASK, 32'h0000_0010);
        busWrite(acrs_pkg::ADDR_IRQ_STATUS, 32'h0000_00EF);
        checkRead(acrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0010);
        checkIrq(1'b1);
        busWrite(acrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0010);
        checkIrq(1'b0);
        storeVal(acrs_pkg::SLOT5_IDX, 10'h0F0);
        checkIrq(1'b0);
        storeVal(acrs_pkg::SLOT5_IDX, 10'h30F);
        checkIrq(1'b1);
        checkRead(slotAddr[0], mkWord(10'h30F, 1'b1, 1'b1));
        busWrite(acrs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        checkIrq(1'b0);
        // unmapped place: write ignored, read returns zero
        busWrite(8'h20, 32'hFFFF_FFFF);
        checkRead(8'h20, 32'h0000_0000);
        checkRead(slotAddr[0], mkWord(10'h30F, 1'b0, 1'b0));
        // reset in mid-run: a loaded slot and the mask return to zero
        storeVal(acrs_pkg::PRIO_IDX, 10'h2C3);
        busWrite(acrs_pkg::ADDR_IRQ_MASK, 32'h0000_00FF);
        checkIrq(1'b1);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        checkIrq(1'b0);
        checkRead(acrs_pkg::ADDR_PRIO, 32'h0000_0000);
        checkRead(acrs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        checkRead(acrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
        give_verdict();
    end

endmodule
